// file: pin_override_consts.svh
`ifndef PIN_OVERRIDE_CONSTS_SVH
`define PIN_OVERRIDE_CONSTS_SVH

// Port C pin positions
`define PORTC_TOP_BIT       6
`define PORTC_CLOCK_BIT     5
`define PORTC_DATA_BIT      4
// Pin change source numbering for port C
`define PORTC_PCINT_BASE    8
// Two-wire spike filter minimum pulse, in ns, and clock period in ns
`define SPIKE_MIN_NS        50
`define CLOCK_PERIOD_NS     25
// Least time rounds up to whole cycles
`define SPIKE_MIN_CYCLES    ((`SPIKE_MIN_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
// Reset values
`define SYNC_RESET_VALUE    1'b0
`define FILTER_RESET_VALUE  1'b1

`endif

// file: pin_override_pkg.sv
package pin_override_pkg;
  // Per-pin override bundle field layout
  typedef struct packed
  {
    logic pullup_override_enable;
    logic pullup_override_value;
    logic direction_override_enable;
    logic direction_override_value;
    logic port_value_override_enable;
    logic port_value_override_value;
    logic input_enable_override_enable;
    logic input_enable_override_value;
  } pin_override_t;
  typedef enum logic {filter_idle, filter_count} filter_state_t;
endpackage : pin_override_pkg

// file: spike_filter.sv
`timescale 1ns/1ps
`default_nettype none
`include "pin_override_consts.svh"

module spike_filter
  import pin_override_pkg::*;
#(
  parameter int unsigned MIN_CYCLES = `SPIKE_MIN_CYCLES
)
(
  input  wire logic i_clock,
  input  wire logic i_arst_n,
  input  wire logic i_raw,
  output logic      o_filtered
);

  logic          sync1_reg;
  logic          sync2_reg;
  logic          out_reg;
  logic          out_next;
  logic [3:0]    count_reg;
  logic [3:0]    count_next;
  filter_state_t state_reg;
  filter_state_t state_next;

  // New level must persist MIN_CYCLES+1 cycles before output follows
  always_comb
  begin
    out_next   = out_reg;
    count_next = count_reg;
    state_next = state_reg;
    case (state_reg)
      filter_idle:
      begin
        count_next = 4'h1;
        if (sync2_reg != out_reg)
          state_next = filter_count;
      end
      filter_count:
      begin
        if (sync2_reg == out_reg)
          state_next = filter_idle; // Short pulse dropped
        else if (count_reg >= 4'(MIN_CYCLES))
        begin
          out_next   = sync2_reg;
          state_next = filter_idle;
        end
        else
          count_next = count_reg + 4'h1;
      end
      default: state_next = filter_idle;
    endcase
  end

  // Two-stage synchroniser, then filter state
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      sync1_reg <= `FILTER_RESET_VALUE;
      sync2_reg <= `FILTER_RESET_VALUE;
      out_reg   <= `FILTER_RESET_VALUE;
      count_reg <= 4'h0;
      state_reg <= filter_idle;
    end
    else
    begin
      sync1_reg <= i_raw;
      sync2_reg <= sync1_reg;
      out_reg   <= out_next;
      count_reg <= count_next;
      state_reg <= state_next;
    end
  end

  assign o_filtered = out_reg;

  a_filter_no_short: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    $changed(out_reg) |-> $past(sync2_reg) == out_reg
      && $past(sync2_reg, 2) == out_reg)
    else $error("filter passed a short pulse");

endmodule : spike_filter
`default_nettype wire

// file: port_b_c_override.sv
`timescale 1ns/1ps
`default_nettype none
`include "pin_override_consts.svh"

//////////////////////////////////////////////////////////////////////////////
// Function
// - Fuse programmed: top C pin is GPIO
// - Fuse unprogrammed: top C pin is reset
// - As reset pin, its direction/latch/input read zero
// - Top C input enable from fuse or pin change
// - Two-wire enable routes C5 as clock
// - Two-wire enable routes C4 as data
// - Two-wire pins open-drain, value zero
// - Two-wire inputs reject pulses under 50ns
// - C5 input enable: pin change or disable
// - C3..C0 override only input enable
// - Port C bit n is source 8+n
// - B3 value from SPI master or timer2
// - B3 to SPI slave, B0 to capture
// - Analog inputs C5/C4 shared with two-wire
module port_b_c_override
  import pin_override_pkg::*;
#(
  parameter int unsigned SPIKE_CYCLES = `SPIKE_MIN_CYCLES
)
(
  input  wire logic       i_clock,
  input  wire logic       i_arst_n,
  input  wire logic       i_reset_pin_disable_fuse,
  input  wire logic       i_global_pullup_disable,
  input  wire logic       i_spi_enable_bit,
  input  wire logic       i_spi_master_select,
  input  wire logic       i_spi_master_out,
  input  wire logic       i_timer2_compare_a_enable,
  input  wire logic       i_timer2_compare_a_out,
  input  wire logic       i_timer1_compare_a_enable,
  input  wire logic       i_timer1_compare_a_out,
  input  wire logic       i_timer1_compare_b_enable,
  input  wire logic       i_timer1_compare_b_out,
  input  wire logic       i_two_wire_enable,
  input  wire logic       i_two_wire_clock_out,
  input  wire logic       i_two_wire_data_out,
  input  wire logic       i_pin_change_group0_enable,
  input  wire logic       i_pin_change_group1_enable,
  input  wire logic [3:0] i_portb_pcint_mask,
  input  wire logic [6:0] i_portc_pcint_mask,
  input  wire logic [5:0] i_analog_digital_input_disable,
  input  wire logic [3:0] i_portb_latch,
  input  wire logic [6:0] i_portc_direction,
  input  wire logic [6:0] i_portc_latch,
  input  wire logic [3:0] i_portb_pin,
  input  wire logic [6:0] i_portc_pin,
  output logic [3:0]      o_portb_pullup_override_enable,
  output logic [3:0]      o_portb_pullup_override_value,
  output logic [3:0]      o_portb_direction_override_enable,
  output logic [3:0]      o_portb_direction_override_value,
  output logic [3:0]      o_portb_port_value_override_enable,
  output logic [3:0]      o_portb_port_value_override_value,
  output logic [3:0]      o_portb_input_enable_override_enable,
  output logic [3:0]      o_portb_input_enable_override_value,
  output logic [6:0]      o_portc_pullup_override_enable,
  output logic [6:0]      o_portc_pullup_override_value,
  output logic [6:0]      o_portc_direction_override_enable,
  output logic [6:0]      o_portc_direction_override_value,
  output logic [6:0]      o_portc_port_value_override_enable,
  output logic [6:0]      o_portc_port_value_override_value,
  output logic [6:0]      o_portc_input_enable_override_enable,
  output logic [6:0]      o_portc_input_enable_override_value,
  output logic [14:0]     o_pin_change_source,
  output logic            o_spi_slave_data_in,
  output logic            o_spi_slave_select_n,
  output logic            o_timer1_capture_input,
  output logic            o_two_wire_clock_in,
  output logic            o_two_wire_data_in,
  output logic            o_reset_pin_connect,
  output logic            o_reset_pin_level,
  output logic [6:0]      o_portc_direction_read,
  output logic [6:0]      o_portc_latch_read,
  output logic [6:0]      o_portc_pin_read
);

  //////////////////////////////////////////////////////////////////////////
  // Pin input synchronisers; first stage read only by the second
  logic [3:0] b_sync1_reg;
  logic [3:0] b_sync2_reg;
  logic [6:0] c_sync1_reg;
  logic [6:0] c_sync2_reg;
  logic [3:0] b_data_reg;
  logic [3:0] b_data_next;
  logic [6:0] c_data_reg;
  logic [6:0] c_data_next;
  logic [14:0] pcint_reg;
  logic [14:0] pcint_next;
  logic       spi_slave_in_reg;
  logic       spi_slave_in_next;
  logic       ss_n_reg;
  logic       ss_n_next;
  logic       capture_reg;
  logic       capture_next;
  logic       rst_level_reg;
  logic       rst_level_next;
  logic [6:0] c_dir_rd_reg;
  logic [6:0] c_dir_rd_next;
  logic [6:0] c_lat_rd_reg;
  logic [6:0] c_lat_rd_next;
  logic [6:0] c_pin_rd_reg;
  logic [6:0] c_pin_rd_next;

  logic          spi_slave;
  logic          spi_master;
  logic          reset_as_pin;
  logic [3:0]    b_pc_term;
  logic [6:0]    c_pc_term;
  pin_override_t b_ovr [3:0];
  pin_override_t c_ovr [6:0];

  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      b_sync1_reg <= {4{`SYNC_RESET_VALUE}};
      b_sync2_reg <= {4{`SYNC_RESET_VALUE}};
      c_sync1_reg <= {7{`SYNC_RESET_VALUE}};
      c_sync2_reg <= {7{`SYNC_RESET_VALUE}};
    end
    else
    begin
      b_sync1_reg <= i_portb_pin;
      b_sync2_reg <= b_sync1_reg;
      c_sync1_reg <= i_portc_pin;
      c_sync2_reg <= c_sync1_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Mode decode
  assign spi_slave    = i_spi_enable_bit & ~i_spi_master_select;
  assign spi_master   = i_spi_enable_bit & i_spi_master_select;
  // Fuse programmed reads as 1 here
  assign reset_as_pin = ~i_reset_pin_disable_fuse;
  assign b_pc_term    = i_portb_pcint_mask & {4{i_pin_change_group0_enable}};
  assign c_pc_term    = i_portc_pcint_mask & {7{i_pin_change_group1_enable}};

  //////////////////////////////////////////////////////////////////////////
  // Port B override decode, one entry per pin
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      b_ovr[i] = '0;
      // Input enable on pin change term, value 1
      b_ovr[i].input_enable_override_enable = b_pc_term[i];
      b_ovr[i].input_enable_override_value  = 1'b1;
    end
    // SPI slave forces B3/B2 to input, pull-up from latch
    for (int i = 2; i < 4; i++)
    begin
      b_ovr[i].pullup_override_enable    = spi_slave;
      b_ovr[i].pullup_override_value     =
        i_portb_latch[i] & ~i_global_pullup_disable;
      b_ovr[i].direction_override_enable = spi_slave;
      b_ovr[i].direction_override_value  = 1'b0;
    end
    // OR of both drivers; either enable alone sets the override, value ORs both outputs
    b_ovr[3].port_value_override_enable =
      spi_master | i_timer2_compare_a_enable;
    b_ovr[3].port_value_override_value  =
      i_spi_master_out | i_timer2_compare_a_out;
    b_ovr[2].port_value_override_enable = i_timer1_compare_b_enable;
    b_ovr[2].port_value_override_value  = i_timer1_compare_b_out;
    b_ovr[1].port_value_override_enable = i_timer1_compare_a_enable;
    b_ovr[1].port_value_override_value  = i_timer1_compare_a_out;
  end

  //////////////////////////////////////////////////////////////////////////
  // Port C override decode
  always_comb
  begin
    for (int i = 0; i < 7; i++)
      c_ovr[i] = '0;
    // C3..C0 and C5/C4: input enable from pin change or analog disable
    for (int i = 0; i < 6; i++)
    begin
      c_ovr[i].input_enable_override_enable =
        c_pc_term[i] | i_analog_digital_input_disable[i];
      c_ovr[i].input_enable_override_value  = c_pc_term[i];
    end
    c_ovr[5].input_enable_override_enable = c_pc_term[5]
      | i_analog_digital_input_disable[5];
    // Two-wire mode: open drain, pull-up still from latch
    for (int i = `PORTC_DATA_BIT; i <= `PORTC_CLOCK_BIT; i++)
    begin
      c_ovr[i].pullup_override_enable     = i_two_wire_enable;
      c_ovr[i].pullup_override_value      =
        i_portc_latch[i] & ~i_global_pullup_disable;
      c_ovr[i].direction_override_enable  = i_two_wire_enable;
      c_ovr[i].port_value_override_enable = i_two_wire_enable;
      c_ovr[i].port_value_override_value  = 1'b0;
    end
    c_ovr[`PORTC_CLOCK_BIT].direction_override_value =
      i_two_wire_clock_out;
    c_ovr[`PORTC_DATA_BIT].direction_override_value  =
      i_two_wire_data_out;
    // Top pin: GPIO override when fuse programmed
    c_ovr[6].pullup_override_enable       = i_reset_pin_disable_fuse;
    c_ovr[6].pullup_override_value        = 1'b1;
    c_ovr[6].direction_override_enable    = i_reset_pin_disable_fuse;
    c_ovr[6].input_enable_override_enable =
      i_reset_pin_disable_fuse | c_pc_term[6];
    c_ovr[6].input_enable_override_value  = i_reset_pin_disable_fuse;
  end

  // Unpack per-pin bundles to port vectors
  generate
    for (genvar g = 0; g < 4; g++)
    begin : gen_b
      assign o_portb_pullup_override_enable[g]       = b_ovr[g].pullup_override_enable;
      assign o_portb_pullup_override_value[g]        = b_ovr[g].pullup_override_value;
      assign o_portb_direction_override_enable[g]    = b_ovr[g].direction_override_enable;
      assign o_portb_direction_override_value[g]     = b_ovr[g].direction_override_value;
      assign o_portb_port_value_override_enable[g]   = b_ovr[g].port_value_override_enable;
      assign o_portb_port_value_override_value[g]    = b_ovr[g].port_value_override_value;
      assign o_portb_input_enable_override_enable[g] = b_ovr[g].input_enable_override_enable;
      assign o_portb_input_enable_override_value[g]  = b_ovr[g].input_enable_override_value;
    end
    for (genvar g = 0; g < 7; g++)
    begin : gen_c
      assign o_portc_pullup_override_enable[g]       = c_ovr[g].pullup_override_enable;
      assign o_portc_pullup_override_value[g]        = c_ovr[g].pullup_override_value;
      assign o_portc_direction_override_enable[g]    = c_ovr[g].direction_override_enable;
      assign o_portc_direction_override_value[g]     = c_ovr[g].direction_override_value;
      assign o_portc_port_value_override_enable[g]   = c_ovr[g].port_value_override_enable;
      assign o_portc_port_value_override_value[g]    = c_ovr[g].port_value_override_value;
      assign o_portc_input_enable_override_enable[g] = c_ovr[g].input_enable_override_enable;
      assign o_portc_input_enable_override_value[g]  = c_ovr[g].input_enable_override_value;
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // Registered input routing to peripherals
  always_comb
  begin
    // Port B input reads 0 without its pin change term; port C is not masked
    b_data_next = b_sync2_reg & b_pc_term;
    c_data_next = c_sync2_reg;
    pcint_next  = '0;
    pcint_next[3:0] = b_sync2_reg & b_pc_term;
    // Port C bit n feeds source 8+n, gated by group enable
    pcint_next[14:8] = c_sync2_reg & c_pc_term;
    spi_slave_in_next = b_sync2_reg[3];
    ss_n_next         = spi_slave ? b_sync2_reg[2] : 1'b1;
    capture_next      = b_sync2_reg[0];
    rst_level_next    = reset_as_pin ? c_sync2_reg[6] : 1'b1;
    // Reset-pin use hides the top bit from software
    c_dir_rd_next = i_portc_direction;
    c_lat_rd_next = i_portc_latch;
    c_pin_rd_next = c_data_next;
    if (reset_as_pin)
    begin
      c_dir_rd_next[6] = 1'b0;
      c_lat_rd_next[6] = 1'b0;
      c_pin_rd_next[6] = 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      b_data_reg       <= '0;
      c_data_reg       <= '0;
      pcint_reg        <= '0;
      spi_slave_in_reg <= 1'b0;
      ss_n_reg         <= 1'b1;
      capture_reg      <= 1'b0;
      rst_level_reg    <= 1'b1;
      c_dir_rd_reg     <= '0;
      c_lat_rd_reg     <= '0;
      c_pin_rd_reg     <= '0;
    end
    else
    begin
      b_data_reg       <= b_data_next;
      c_data_reg       <= c_data_next;
      pcint_reg        <= pcint_next;
      spi_slave_in_reg <= spi_slave_in_next;
      ss_n_reg         <= ss_n_next;
      capture_reg      <= capture_next;
      rst_level_reg    <= rst_level_next;
      c_dir_rd_reg     <= c_dir_rd_next;
      c_lat_rd_reg     <= c_lat_rd_next;
      c_pin_rd_reg     <= c_pin_rd_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Two-wire inputs: same pad as analog inputs 5 and 4, filtered
  spike_filter #(.MIN_CYCLES(SPIKE_CYCLES)) u_clock_filter
  (
    .i_clock    (i_clock),
    .i_arst_n   (i_arst_n),
    .i_raw      (i_portc_pin[`PORTC_CLOCK_BIT]),
    .o_filtered (o_two_wire_clock_in)
  );

  spike_filter #(.MIN_CYCLES(SPIKE_CYCLES)) u_data_filter
  (
    .i_clock    (i_clock),
    .i_arst_n   (i_arst_n),
    .i_raw      (i_portc_pin[`PORTC_DATA_BIT]),
    .o_filtered (o_two_wire_data_in)
  );

  assign o_pin_change_source    = pcint_reg;
  assign o_spi_slave_data_in    = spi_slave_in_reg;
  assign o_spi_slave_select_n   = ss_n_reg;
  assign o_timer1_capture_input = capture_reg;
  assign o_reset_pin_connect    = reset_as_pin;
  assign o_reset_pin_level      = rst_level_reg;
  assign o_portc_direction_read = c_dir_rd_reg;
  assign o_portc_latch_read     = c_lat_rd_reg;
  assign o_portc_pin_read       = c_pin_rd_reg;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  a_reset_reads_zero: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    $past(reset_as_pin) |-> !o_portc_direction_read[6]
      && !o_portc_latch_read[6] && !o_portc_pin_read[6])
    else $error("reset pin bits not zero");
  a_top_input_enable: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    o_portc_input_enable_override_enable[6] == (i_reset_pin_disable_fuse
      | (i_portc_pcint_mask[6] & i_pin_change_group1_enable)))
    else $error("top pin input enable wrong");
  a_two_wire_clock: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    i_two_wire_enable |-> o_portc_direction_override_value[5]
      == i_two_wire_clock_out)
    else $error("clock pin not routed");
  a_two_wire_data: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    i_two_wire_enable |-> o_portc_direction_override_value[4]
      == i_two_wire_data_out)
    else $error("data pin not routed");
  a_open_drain_zero: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    i_two_wire_enable |-> o_portc_port_value_override_enable[5:4] == 2'b11
      && o_portc_port_value_override_value[5:4] == 2'b00)
    else $error("two-wire not open drain");
  a_low_c_only_input: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    o_portc_port_value_override_enable[3:0] == 4'h0
      && o_portc_direction_override_enable[3:0] == 4'h0)
    else $error("low port C overridden");
  a_pcint_mapping: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    o_pin_change_source[14:8] == ($past(c_sync2_reg)
      & $past(c_pc_term)))
    else $error("pin change mapping wrong");
  a_b3_value: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (spi_master && !i_timer2_compare_a_enable) |->
      o_portb_port_value_override_value[3] ==
      (i_spi_master_out | i_timer2_compare_a_out))
    else $error("port B3 value wrong");
  a_spi_slave_input: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    spi_slave |-> o_portb_direction_override_enable[3:2] == 2'b11
      && o_portb_direction_override_value[3:2] == 2'b00)
    else $error("SPI slave pins not input");
  c_two_wire_on: cover property (@(posedge i_clock) i_two_wire_enable);
  c_reset_as_gpio: cover property (@(posedge i_clock) i_reset_pin_disable_fuse);
  c_spi_slave: cover property (@(posedge i_clock) spi_slave);

endmodule : port_b_c_override
`default_nettype wire

// file: two_wire_pad_model.sv
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
module two_wire_pad_model
(
  input  wire logic [1:0] i_direction_override_enable,
  input  wire logic [1:0] i_direction_override_value,
  input  wire logic [1:0] i_port_value_override_enable,
  input  wire logic [1:0] i_port_value_override_value,
  input  wire logic [1:0] i_glitch,
  output logic [1:0]      o_pad
);
  // Bus pull-up wins unless a party sinks the line; glitch mimics noise
  assign o_pad = ~((i_direction_override_enable & i_direction_override_value & i_port_value_override_enable & ~i_port_value_override_value) | i_glitch);
endmodule : two_wire_pad_model
`default_nettype wire

// file: port_b_c_alternate_function_override_tb.sv
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
module port_b_c_alternate_function_override_tb;
  import pin_override_pkg::*;
  logic       clock, arst_n, fuse, global_pullup_disable, spi_enable_bit, spi_master_select, mo, t2e, t2o;
  logic       t1ae, t1ao, t1be, t1bo, twe, sclo, sdao, pin_change_group0_enable, pin_change_group1_enable;
  logic [3:0] bmask, blat, bpin;
  logic [6:0] cmask, cdir, clat, cpin;
  logic [5:0] adis;
  logic [1:0] glitch;
  wire logic [1:0] pad;
  wire logic [3:0] bpuoe, bpuov, bddoe, bddov, bpvoe, bpvov, bdie, bdiv;
  wire logic [6:0] cpuoe, cpuov, cddoe, cddov, cpvoe, cpvov, cdie, cdiv;
  wire logic [6:0] cdr, clr, cpr;
  wire logic [14:0] src;
  wire logic       mosi_in, ss_n, cap, sclin, sdain, rconn, rlev;
  int              err_total, n_tests, cycles;

  port_b_c_override uut (.i_clock(clock), .i_arst_n(arst_n),
    .i_reset_pin_disable_fuse(fuse), .i_global_pullup_disable(global_pullup_disable),
    .i_spi_enable_bit(spi_enable_bit), .i_spi_master_select(spi_master_select),
    .i_spi_master_out(mo), .i_timer2_compare_a_enable(t2e),
    .i_timer2_compare_a_out(t2o), .i_timer1_compare_a_enable(t1ae),
    .i_timer1_compare_a_out(t1ao), .i_timer1_compare_b_enable(t1be),
    .i_timer1_compare_b_out(t1bo), .i_two_wire_enable(twe),
    .i_two_wire_clock_out(sclo), .i_two_wire_data_out(sdao),
    .i_pin_change_group0_enable(pin_change_group0_enable), .i_pin_change_group1_enable(pin_change_group1_enable),
    .i_portb_pcint_mask(bmask), .i_portc_pcint_mask(cmask),
    .i_analog_digital_input_disable(adis), .i_portb_latch(blat),
    .i_portc_direction(cdir), .i_portc_latch(clat), .i_portb_pin(bpin),
    .i_portc_pin({cpin[6], pad, cpin[3:0]}),
    .o_portb_pullup_override_enable(bpuoe),
    .o_portb_pullup_override_value(bpuov),
    .o_portb_direction_override_enable(bddoe),
    .o_portb_direction_override_value(bddov),
    .o_portb_port_value_override_enable(bpvoe),
    .o_portb_port_value_override_value(bpvov),
    .o_portb_input_enable_override_enable(bdie),
    .o_portb_input_enable_override_value(bdiv),
    .o_portc_pullup_override_enable(cpuoe),
    .o_portc_pullup_override_value(cpuov),
    .o_portc_direction_override_enable(cddoe),
    .o_portc_direction_override_value(cddov),
    .o_portc_port_value_override_enable(cpvoe),
    .o_portc_port_value_override_value(cpvov),
    .o_portc_input_enable_override_enable(cdie),
    .o_portc_input_enable_override_value(cdiv),
    .o_pin_change_source(src), .o_spi_slave_data_in(mosi_in),
    .o_spi_slave_select_n(ss_n), .o_timer1_capture_input(cap),
    .o_two_wire_clock_in(sclin), .o_two_wire_data_in(sdain),
    .o_reset_pin_connect(rconn), .o_reset_pin_level(rlev),
    .o_portc_direction_read(cdr), .o_portc_latch_read(clr),
    .o_portc_pin_read(cpr));

  two_wire_pad_model pads (.i_direction_override_enable(cddoe[5:4]), .i_direction_override_value(cddov[5:4]),
    .i_port_value_override_enable(cpvoe[5:4]), .i_port_value_override_value(cpvov[5:4]), .i_glitch(glitch),
    .o_pad(pad));

  //////////////////////////////////////////////////////////////////////////
  // Clock and hang guard; generous ceiling, tests need well under 400
  always #12.5 clock = ~clock;
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_total++;
      print_verdict();
    end
  end

  task automatic go(input int n);
    repeat (n) @(posedge clock);
  endtask : go

  task automatic cmp(input logic [14:0] got, input logic [14:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  //////////////////////////////////////////////////////////////////////////
  // Main sequence; registered paths get 8 cycles, above the 5-cycle worst
  initial
  begin
    {clock, arst_n, fuse, global_pullup_disable, spi_enable_bit, spi_master_select, mo, t2e, t2o} = '0;
    {t1ae, t1ao, t1be, t1bo, twe, sclo, sdao, pin_change_group0_enable, pin_change_group1_enable} = '0;
    {bmask, blat, bpin, cmask, cdir, clat, cpin, adis, glitch} = '0;
    go(2);
    arst_n <= 1'b1;
    go(1);
    cpin <= 7'h3F; cdir <= 7'h7F; clat <= 7'h7F;
    go(8); #1;
    cmp(rconn, 1'b1);
    cmp(rlev, 1'b0);
    cmp({cdr[6], clr[6], cpr[6]}, 3'b000);
    cmp(cdie[6], 1'b0);
    go(1);
    cmask <= 7'h40; pin_change_group1_enable <= 1'b1;
    go(1); #1;
    cmp({cdie[6], cdiv[6]}, 2'b10);
    go(1);
    fuse <= 1'b1; cpin <= 7'h7F;
    go(8); #1;
    cmp(rconn, 1'b0);
    cmp(rlev, 1'b1);
    cmp({cdr[6], clr[6], cpr[6]}, 3'b111);
    cmp({cdie[6], cdiv[6]}, 2'b11);
    $display("Test reset pin done");
    go(1);
    cdir <= 7'h00; twe <= 1'b1; sclo <= 1'b1;
    go(8); #1;
    cmp(cpvoe, 7'h30);
    cmp({cpvov[5:4], cddoe[5:4], cddov[5:4]}, 6'h0E);
    cmp(cpuov[5:4], 2'b11);
    cmp(cpuoe, 7'h70);
    cmp({sclin, sdain}, 2'b01);
    go(1);
    global_pullup_disable <= 1'b1; sclo <= 1'b0; sdao <= 1'b1;
    go(8); #1;
    cmp(cpuov[5:4], 2'b00);
    cmp({sclin, sdain}, 2'b10);
    go(1);
    sdao <= 1'b0;
    go(8);
    glitch <= 2'b11;
    go(1);
    glitch <= 2'b00;
    repeat (8)
    begin
      go(1); #1;
      cmp({sclin, sdain}, 2'b11);
    end
    glitch <= 2'b10;
    go(8); #1;
    cmp({sclin, sdain}, 2'b01);
    $display("Test two-wire done");
    go(1);
    glitch <= 2'b00; twe <= 1'b0; cmask <= 7'h00;
    for (int n = 0; n < 6; n++)
    begin
      go(1);
      pin_change_group1_enable <= 1'b0; adis <= 6'(1 << n);
      go(1); #1;
      cmp({cdie[n], cdiv[n]}, 2'b10);
      go(1);
      pin_change_group1_enable <= 1'b1; adis <= 6'h00; cmask <= 7'(1 << n);
      go(1); #1;
      cmp({cdie[n], cdiv[n]}, 2'b11);
    end
    $display("Test input enables done");
    go(1);
    cmask <= 7'h7F; bmask <= 4'hF; pin_change_group0_enable <= 1'b1; bpin <= 4'hF;
    go(8); #1;
    cmp(src, 15'h7F0F);
    cmp({cap, mosi_in}, 2'b11);
    cmp({bdie, bdiv}, 8'hFF);
    go(1);
    pin_change_group1_enable <= 1'b0;
    go(8); #1;
    cmp(src, 15'h000F);
    $display("Test pin change done");
    go(1);
    mo <= 1'b0; t2o <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      go(1);
      spi_enable_bit <= i[2]; spi_master_select <= i[1]; t2e <= i[0];
      go(1); #1;
      cmp(bpvoe[3], (i[2] & i[1]) | i[0]);
      if (bpvoe[3] === 1'b1)
        cmp(bpvov[3], 1'b1);
      cmp({bpuoe[3:2], bddoe[3:2]}, {4{i[2] & ~i[1]}});
    end
    go(1);
    spi_enable_bit <= 1'b1; spi_master_select <= 1'b0; global_pullup_disable <= 1'b0; blat <= 4'hC; bpin <= 4'hB;
    t1ae <= 1'b1; t1ao <= 1'b1; t1be <= 1'b1; t1bo <= 1'b0;
    go(8); #1;
    cmp({bpuov[3:2], bddov[3:2]}, 4'hC);
    cmp(ss_n, 1'b0);
    cmp({bpvoe[2:1], bpvov[2:1]}, 4'hD);
    $display("Test port B done");
    print_verdict();
  end
endmodule : port_b_c_alternate_function_override_tb
`default_nettype wire
